// File: djc_cfg.svh
// register offsets, field positions, reset values and counts of the strap decoder
`ifndef DJC_CFG_SVH
`define DJC_CFG_SVH
`define DJC_OFS_CTRL 8'h00
`define DJC_OFS_STAT 8'h04
`define DJC_OFS_CMD 8'h08
`define DJC_CTRL_RST 32'h0000_0000
`define DJC_CTRL_PROTO_BIT 0
`define DJC_CTRL_SWWP_BIT 1
`define DJC_CTRL_SYNCEN_BIT 2
`define DJC_CTRL_MODE_LSB 3
`define DJC_CMD_DONE_BIT 8
`define DJC_CMD_NR_BIT 9
`define DJC_SETTLE_CYC 3'h4
`define DJC_SYNC_HALF_CYC 16'h0FA0
`define DJC_OP_REQ_SENSE 8'h03
`define DJC_OP_INQUIRY 8'h12
`define DJC_OP_RESERVE 8'h16
`define DJC_OP_RELEASE 8'h17
`define DJC_OP_START 8'h1B
`endif

// File: djc_pkg.sv
// types shared by the strap decoder modules
package djc_pkg;
   typedef enum logic [1:0] {
      SPIN_IDLE = 2'b00,
      SPIN_UP = 2'b01,
      SPIN_READY = 2'b10
   } djc_spin_e;
   typedef enum logic [1:0] {
      SYNC_ALONE = 2'b00,
      SYNC_SLAVE = 2'b01,
      SYNC_MASTER = 2'b10,
      SYNC_MCTRL = 2'b11
   } djc_sync_e;
   typedef struct packed {
      logic cfg_valid;
      logic [2:0] settle;
      logic auto_spin;
      logic sdtr_en;
      logic scsi1_strap;
      logic wp_strap;
      logic [1:0] route_strap;
      logic page_scsi1;
      logic sw_wp;
      logic sync_en;
      djc_sync_e sync_mode;
      djc_spin_e spin;
      logic [15:0] sync_cnt;
      logic sync_lvl;
      logic [3:0] bus_id;
      logic par_chk_en;
      logic ua_en;
      logic scsi1_mode;
      logic wprot;
      logic spin_en;
      logic unit_ready;
      logic sync_oe;
      logic lock_ext;
      logic lock_ref;
      logic [1:0] sync_route;
      logic sdtr_start;
      logic sdtr_reply;
      logic tx_parity;
      logic par_err;
      logic cmd_valid;
      logic [7:0] cmd_op;
      logic res_done;
      logic res_nr;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } djc_top_s;
endpackage

// File: djc_cmd_if.sv
// command hand-off between the register block and the command gate
`timescale 1ns/1ps
interface djc_cmd_if;
   logic valid;
   logic [7:0] opcode;
   logic unit_ready;
   logic done;
   logic not_ready;
   logic start_req;
   modport gate (input valid, opcode, unit_ready, output done, not_ready, start_req);
   modport ctl (output valid, opcode, unit_ready, input done, not_ready, start_req);
endinterface

// File: djc_strap_sync.sv
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/1ps
module djc_strap_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } djc_sync_s;
   djc_sync_s s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.s1 = din;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      for (int i = 0; i < W; i++) begin
         if (s_q.s2[i] == s_q.s3[i]) begin
            s_d.q[i] = s_q.s3[i];
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign dout = s_q.q;
endmodule

// File: djc_cmd_gate.sv
// admits or refuses commands while the unit is not yet ready
`timescale 1ns/1ps
`include "djc_cfg.svh"
module djc_cmd_gate (
   input wire logic clk,
   input wire logic rst_n,
   djc_cmd_if.gate cmd
);
   typedef struct packed {
      logic done;
      logic not_ready;
      logic start_req;
   } djc_gate_s;
   djc_gate_s s_q, s_d;
   logic exempt;
   always_comb begin
      exempt = (cmd.opcode == `DJC_OP_REQ_SENSE) || (cmd.opcode == `DJC_OP_INQUIRY) ||
               (cmd.opcode == `DJC_OP_RESERVE) || (cmd.opcode == `DJC_OP_RELEASE) ||
               (cmd.opcode == `DJC_OP_START);
      s_d = '0;
      if (cmd.valid) begin
         s_d.done = 1'b1;
         s_d.not_ready = !cmd.unit_ready && !exempt; // R3
         s_d.start_req = (cmd.opcode == `DJC_OP_START); // R2
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign cmd.done = s_q.done;
   assign cmd.not_ready = s_q.not_ready;
   assign cmd.start_req = s_q.start_req;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_refused_cmd;
      cmd.valid && !cmd.unit_ready && !exempt;
   endsequence
   sequence s_answer_nr;
      cmd.done && cmd.not_ready;
   endsequence
   property p_not_ready;
      s_refused_cmd |=> s_answer_nr;
   endproperty
   a_not_ready: assert property (p_not_ready) else $error("refused command not answered"); // R3
   property p_exempt_ok;
      cmd.valid && exempt |=> cmd.done && !cmd.not_ready;
   endproperty
   a_exempt_ok: assert property (p_exempt_ok) else $error("exempt command refused"); // R3
endmodule

// File: djc_top.sv
// strap decoder: samples jumpers and drives the drive's configuration
// What this block does
// R1 - shorted auto-spin strap spins up at power-on
// R2 - open auto-spin strap waits for START UNIT
// R3 - not ready refuses all but five commands
// R4 - parity strap enables incoming parity checks
// R5 - outgoing parity always generated
// R6 - open protocol strap follows mode page bit
// R7 - shorted protocol strap forces SCSI-1 behaviour
// R8 - narrow bus address from three straps
// R9 - wide bus address from four straps
// R10 - sync routing ignored while sync disabled
// R11 - standalone, slave, master supported; standalone at reset
// R12 - standalone: no sync drive, no lock
// R13 - slave: no sync drive, lock external
// R14 - master: drive sync and lock to it
// R15 - shorted negotiation strap starts SDTR after resets
// R16 - host SDTR always answered
// R17 - shorted unit-attention strap disables reporting
// R18 - shorted write-protect strap blocks all writes
// R19 - open write-protect strap: software controls protection
// R20 - straps sampled after reset, held until reset
`timescale 1ns/1ps
`include "djc_cfg.svh"
module djc_top #(
   parameter bit WIDE_BUS = 1'b0,
   parameter logic [15:0] SYNC_HALF = `DJC_SYNC_HALF_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic strap_auto_spin,
   input wire logic strap_parity,
   input wire logic strap_scsi1,
   input wire logic [3:0] strap_addr,
   input wire logic [1:0] strap_sync_route,
   input wire logic strap_sdtr,
   input wire logic strap_ua_off,
   input wire logic strap_wprot,
   input wire logic sync_in,
   input wire logic spin_at_speed,
   input wire logic bus_reset,
   input wire logic host_sdtr,
   input wire logic rx_par_err,
   input wire logic [7:0] tx_byte,
   output logic spin_en,
   output logic unit_ready,
   output logic [3:0] bus_id,
   output logic par_chk_en,
   output logic par_err,
   output logic tx_parity,
   output logic scsi1_mode,
   output logic ua_en,
   output logic wprot,
   output logic sync_out,
   output logic sync_oe,
   output logic lock_ext,
   output logic lock_ref,
   output logic [1:0] sync_route,
   output logic sdtr_start,
   output logic sdtr_reply
);
   import djc_pkg::*;

   // ***************************************************************
   // strap and pin synchronisers
   // ***************************************************************
   logic [11:0] straps_s;
   logic sync_in_s;
   djc_top_s s_q, s_d;
   djc_cmd_if cmd_if ();

   djc_strap_sync #(.W(12)) u_strap_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din({strap_auto_spin, strap_parity, strap_scsi1, strap_sdtr, strap_ua_off,
            strap_wprot, strap_sync_route, strap_addr}),
      .dout(straps_s)
   );
   djc_strap_sync #(.W(1)) u_sync_in_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(sync_in),
      .dout(sync_in_s)
   );
   djc_cmd_gate u_cmd_gate (
      .clk(pclk),
      .rst_n(presetn),
      .cmd(cmd_if.gate)
   );
   assign cmd_if.valid = s_q.cmd_valid;
   assign cmd_if.opcode = s_q.cmd_op;
   assign cmd_if.unit_ready = s_q.unit_ready;

   // ***************************************************************
   // next-state logic
   // ***************************************************************
   djc_sync_e eff_mode;
   logic wr_acc;
   logic setup;
   always_comb begin
      s_d = s_q;
      wr_acc = psel && penable && pwrite && s_q.pready;
      setup = psel && !penable;
      // strap capture once the synchronisers have settled
      if (!s_q.cfg_valid) begin
         if (s_q.settle != `DJC_SETTLE_CYC) begin
            s_d.settle = s_q.settle + 3'h1;
         end else begin
            s_d.cfg_valid = 1'b1; // R20
            s_d.auto_spin = straps_s[11];
            s_d.par_chk_en = straps_s[10]; // R4
            s_d.scsi1_strap = straps_s[9];
            s_d.sdtr_en = straps_s[8];
            s_d.ua_en = !straps_s[7]; // R17
            s_d.wp_strap = straps_s[6];
            s_d.route_strap = straps_s[5:4];
            if (WIDE_BUS) begin
               s_d.bus_id = straps_s[3:0]; // R9
            end else begin
               s_d.bus_id = {1'b0, straps_s[2:0]}; // R8
            end
            s_d.sdtr_start = straps_s[8]; // R15
         end
      end else begin
         s_d.sdtr_start = s_q.sdtr_en && bus_reset; // R15
      end
      s_d.sdtr_reply = host_sdtr; // R16
      // register writes
      if (wr_acc && paddr == `DJC_OFS_CTRL) begin
         s_d.page_scsi1 = pwdata[`DJC_CTRL_PROTO_BIT];
         s_d.sw_wp = pwdata[`DJC_CTRL_SWWP_BIT];
         s_d.sync_en = pwdata[`DJC_CTRL_SYNCEN_BIT];
         if (pwdata[`DJC_CTRL_MODE_LSB+:2] != SYNC_MCTRL) begin
            s_d.sync_mode = djc_sync_e'(pwdata[`DJC_CTRL_MODE_LSB+:2]); // R11
         end
      end
      s_d.cmd_valid = wr_acc && paddr == `DJC_OFS_CMD;
      if (s_d.cmd_valid) begin
         s_d.cmd_op = pwdata[7:0];
         s_d.res_done = 1'b0;
         s_d.res_nr = 1'b0;
      end else if (cmd_if.done) begin
         s_d.res_done = 1'b1;
         s_d.res_nr = cmd_if.not_ready; // R3
      end
      // decoded configuration
      s_d.scsi1_mode = s_q.scsi1_strap || s_q.page_scsi1; // R6 R7
      s_d.wprot = s_q.wp_strap || s_q.sw_wp; // R18 R19
      s_d.tx_parity = ~^tx_byte; // R5
      s_d.par_err = s_q.par_chk_en && rx_par_err; // R4
      // spindle start
      unique case (s_q.spin)
         SPIN_IDLE: begin
            if (s_q.cfg_valid && (s_q.auto_spin || cmd_if.start_req)) begin
               s_d.spin = SPIN_UP; // R1 R2
            end
         end
         SPIN_UP: begin
            if (spin_at_speed) begin
               s_d.spin = SPIN_READY;
            end
         end
         SPIN_READY: begin
            s_d.spin = SPIN_READY;
         end
         default: begin
            s_d.spin = SPIN_IDLE;
         end
      endcase
      s_d.spin_en = (s_d.spin != SPIN_IDLE);
      s_d.unit_ready = (s_d.spin == SPIN_READY);
      // spindle synchronisation
      eff_mode = s_q.sync_en ? s_q.sync_mode : SYNC_ALONE;
      s_d.sync_route = s_q.sync_en ? s_q.route_strap : 2'b00; // R10
      if (eff_mode == SYNC_MASTER) begin
         if (s_q.sync_cnt >= SYNC_HALF - 16'h0001) begin
            s_d.sync_cnt = 16'h0000;
            s_d.sync_lvl = !s_q.sync_lvl;
         end else begin
            s_d.sync_cnt = s_q.sync_cnt + 16'h0001;
         end
      end else begin
         s_d.sync_cnt = 16'h0000;
         s_d.sync_lvl = 1'b0;
      end
      s_d.sync_oe = (eff_mode == SYNC_MASTER); // R12 R13 R14
      s_d.lock_ext = (eff_mode == SYNC_SLAVE); // R13
      unique case (eff_mode)
         SYNC_SLAVE: s_d.lock_ref = sync_in_s; // R13
         SYNC_MASTER: s_d.lock_ref = s_q.sync_lvl; // R14
         default: s_d.lock_ref = 1'b0; // R12
      endcase
      // APB answer prepared in the setup cycle
      s_d.pready = setup;
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      if (setup) begin
         unique case (paddr)
            `DJC_OFS_CTRL: begin
               s_d.prdata = {27'h0, s_q.sync_mode, s_q.sync_en, s_q.sw_wp, s_q.page_scsi1};
            end
            `DJC_OFS_STAT: begin
               s_d.prdata = {18'h0, s_q.route_strap, s_q.sdtr_en, s_q.par_chk_en, s_q.ua_en,
                             s_q.wprot, s_q.scsi1_mode, s_q.bus_id, s_q.spin, s_q.cfg_valid};
            end
            `DJC_OFS_CMD: begin
               s_d.prdata = {22'h0, s_q.res_nr, s_q.res_done, s_q.cmd_op};
            end
            default: begin
               s_d.pslverr = 1'b1;
            end
         endcase
      end
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign spin_en = s_q.spin_en;
   assign unit_ready = s_q.unit_ready;
   assign bus_id = s_q.bus_id;
   assign par_chk_en = s_q.par_chk_en;
   assign par_err = s_q.par_err;
   assign tx_parity = s_q.tx_parity;
   assign scsi1_mode = s_q.scsi1_mode;
   assign ua_en = s_q.ua_en;
   assign wprot = s_q.wprot;
   assign sync_out = s_q.sync_lvl;
   assign sync_oe = s_q.sync_oe;
   assign lock_ext = s_q.lock_ext;
   assign lock_ref = s_q.lock_ref;
   assign sync_route = s_q.sync_route;
   assign sdtr_start = s_q.sdtr_start;
   assign sdtr_reply = s_q.sdtr_reply;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_auto_spin;
      $rose(s_q.cfg_valid) && s_q.auto_spin |=> spin_en ##1 spin_en;
   endproperty
   a_auto_spin: assert property (p_auto_spin) else $error("no auto spin-up"); // R1
   property p_manual_hold;
      s_q.cfg_valid && !s_q.auto_spin && !spin_en && !cmd_if.start_req |=> !spin_en;
   endproperty
   a_manual_hold: assert property (p_manual_hold) else $error("spun without start"); // R2
   property p_par_off;
      rx_par_err && !par_chk_en |=> !par_err;
   endproperty
   a_par_off: assert property (p_par_off) else $error("parity checked while off"); // R4
   property p_tx_par;
      presetn |=> ^{tx_parity, $past(tx_byte)} == 1'b1;
   endproperty
   a_tx_par: assert property (p_tx_par) else $error("outgoing parity not odd"); // R5
   property p_scsi1;
      s_q.cfg_valid && s_q.scsi1_strap |=> scsi1_mode;
   endproperty
   a_scsi1: assert property (p_scsi1) else $error("scsi1 strap not forcing"); // R7
   property p_hold;
      s_q.cfg_valid |=> s_q.cfg_valid && $stable(bus_id) && $stable(ua_en) && $stable(par_chk_en);
   endproperty
   a_hold: assert property (p_hold) else $error("strap decode changed"); // R20
   property p_route_off;
      !s_q.sync_en |=> sync_route == 2'b00 && !sync_oe;
   endproperty
   a_route_off: assert property (p_route_off) else $error("routing used while disabled"); // R10
   property p_master;
      s_q.sync_en && s_q.sync_mode == SYNC_MASTER |=> sync_oe && !lock_ext;
   endproperty
   a_master: assert property (p_master) else $error("master not driving sync"); // R14
   property p_sdtr_reply;
      host_sdtr |=> sdtr_reply;
   endproperty
   a_sdtr_reply: assert property (p_sdtr_reply) else $error("host SDTR not answered"); // R16
   property p_sdtr_quiet;
      s_q.cfg_valid && !s_q.sdtr_en |=> !sdtr_start;
   endproperty
   a_sdtr_quiet: assert property (p_sdtr_quiet) else $error("SDTR started while off"); // R15
   property p_wp;
      s_q.cfg_valid && s_q.wp_strap |=> wprot;
   endproperty
   a_wp: assert property (p_wp) else $error("write protect strap ignored"); // R18
   sequence s_capture;
      !s_q.cfg_valid && s_q.settle == `DJC_SETTLE_CYC;
   endsequence
   property p_bus_id;
      s_capture |=> bus_id == (WIDE_BUS ? $past(straps_s[3:0]) : {1'b0, $past(straps_s[2:0])});
   endproperty
   a_bus_id: assert property (p_bus_id) else $error("bus address decode wrong"); // R8 R9
   property p_ua;
      s_capture |=> ua_en == !$past(straps_s[7]);
   endproperty
   a_ua: assert property (p_ua) else $error("unit attention decode wrong"); // R17
   property p_sdtr_boot;
      s_capture |=> sdtr_start == $past(straps_s[8]);
   endproperty
   a_sdtr_boot: assert property (p_sdtr_boot) else $error("start-up SDTR wrong"); // R15
   property p_sdtr_reset;
      s_q.sdtr_en && bus_reset |=> sdtr_start;
   endproperty
   a_sdtr_reset: assert property (p_sdtr_reset) else $error("no SDTR after bus reset"); // R15
   property p_par_on;
      rx_par_err && par_chk_en |=> par_err;
   endproperty
   a_par_on: assert property (p_par_on) else $error("parity error not flagged"); // R4
   property p_manual_go;
      s_q.cfg_valid && s_q.spin == SPIN_IDLE && cmd_if.start_req |=> spin_en;
   endproperty
   a_manual_go: assert property (p_manual_go) else $error("start unit ignored"); // R2
   property p_page;
      s_q.cfg_valid && !s_q.scsi1_strap |=> scsi1_mode == $past(s_q.page_scsi1);
   endproperty
   a_page: assert property (p_page) else $error("protocol level not from page bit"); // R6
   property p_sw_wp;
      s_q.cfg_valid && !s_q.wp_strap |=> wprot == $past(s_q.sw_wp);
   endproperty
   a_sw_wp: assert property (p_sw_wp) else $error("software write protect ignored"); // R19
   property p_no_mctrl;
      s_q.sync_mode != SYNC_MCTRL;
   endproperty
   a_no_mctrl: assert property (p_no_mctrl) else $error("master control mode taken"); // R11
   property p_alone;
      !s_q.sync_en || s_q.sync_mode == SYNC_ALONE |=> !sync_oe && !lock_ext && !lock_ref;
   endproperty
   a_alone: assert property (p_alone) else $error("standalone mode not quiet"); // R12
   property p_slave;
      s_q.sync_en && s_q.sync_mode == SYNC_SLAVE |=>
         !sync_oe && lock_ext && lock_ref == $past(sync_in_s);
   endproperty
   a_slave: assert property (p_slave) else $error("slave not locked to input"); // R13
   property p_master_ref;
      s_q.sync_en && s_q.sync_mode == SYNC_MASTER |=> lock_ref == $past(sync_out);
   endproperty
   a_master_ref: assert property (p_master_ref) else $error("master not locked to own sync"); // R14
endmodule

// File: djc_host_model.sv
// initiator-side model: bus events, outgoing bytes, pulse counters
`timescale 1ns/1ps
module djc_host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sdtr_start,
   input wire logic sdtr_reply,
   input wire logic par_err,
   output logic bus_reset,
   output logic host_sdtr,
   output logic rx_par_err,
   output logic [7:0] tx_byte,
   output logic sync_in
);
   int n_start;
   int n_reply;
   int n_perr;
   initial begin
      bus_reset = 1'b0;
      host_sdtr = 1'b0;
      rx_par_err = 1'b0;
      tx_byte = 8'h00;
      sync_in = 1'b0;
   end
   // free external spindle reference, slow enough for the three-stage synchroniser
   logic [2:0] sync_div = 3'h0;
   always @(posedge pclk) begin
      sync_div <= sync_div + 3'h1;
      if (sync_div == 3'h7) begin
         sync_in <= ~sync_in;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_start <= 0;
         n_reply <= 0;
         n_perr <= 0;
      end else begin
         n_start <= n_start + int'(sdtr_start);
         n_reply <= n_reply + int'(sdtr_reply);
         n_perr <= n_perr + int'(par_err);
      end
   end
   // one-cycle event: 0 bus reset, 1 host negotiation, 2 bad parity byte
   task automatic pulse(input int k);
      @(posedge pclk);
      bus_reset <= (k == 0);
      host_sdtr <= (k == 1);
      rx_par_err <= (k == 2);
      @(posedge pclk);
      bus_reset <= 1'b0;
      host_sdtr <= 1'b0;
      rx_par_err <= 1'b0;
   endtask
   task automatic send(input logic [7:0] v);
      @(posedge pclk);
      tx_byte <= v;
   endtask
endmodule

// File: djc_tb.sv
// self-checking bench for the strap decoder
`timescale 1ns/1ps
`include "djc_cfg.svh"
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, at_speed = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   logic s_spin, s_par, s_sc1, s_sdtr, s_ua, s_wp;
   logic [3:0] s_addr;
   logic [1:0] s_route;
   logic bus_reset, host_sdtr, rx_par_err, sync_in, tx_parity, spin_en, unit_ready;
   logic par_chk_en, par_err, scsi1_mode, ua_en, wprot, sync_out, sync_oe, lock_ext;
   logic lock_ref, sdtr_start, sdtr_reply, x0;
   logic [7:0] tx_byte;
   logic [3:0] bus_id;
   logic [1:0] sync_route;
   logic [7:0] bytes [4] = '{8'hA5, 8'h01, 8'h00, 8'hFE};
   logic [7:0] free_ops [4] = '{`DJC_OP_REQ_SENSE, `DJC_OP_INQUIRY, `DJC_OP_RESERVE,
      `DJC_OP_RELEASE};
   int fail_count = 0;
   int checked = 0;
   always #2.5 pclk = ~pclk;
   djc_top #(.WIDE_BUS(1'b0), .SYNC_HALF(16'h0004)) djc_top_i (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .strap_auto_spin(s_spin), .strap_parity(s_par), .strap_scsi1(s_sc1),
      .strap_addr(s_addr), .strap_sync_route(s_route), .strap_sdtr(s_sdtr),
      .strap_ua_off(s_ua), .strap_wprot(s_wp), .sync_in, .spin_at_speed(at_speed),
      .bus_reset, .host_sdtr, .rx_par_err, .tx_byte, .spin_en, .unit_ready, .bus_id,
      .par_chk_en, .par_err, .tx_parity, .scsi1_mode, .ua_en, .wprot, .sync_out, .sync_oe,
      .lock_ext, .lock_ref, .sync_route, .sdtr_start, .sdtr_reply);
   djc_host_model djc_host_model_i (.pclk, .presetn, .sdtr_start, .sdtr_reply, .par_err,
      .bus_reset, .host_sdtr, .rx_par_err, .tx_byte, .sync_in);
   // ************
   // tasks
   // ************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle;
      repeat (4) @(posedge pclk);
   endtask
   task automatic restart(input logic [7:0] s, input logic [3:0] a, input logic [1:0] r);
      @(posedge pclk);
      presetn <= 1'b0;
      s_spin <= s[5];
      s_par <= s[4];
      s_sc1 <= s[3];
      s_sdtr <= s[2];
      s_ua <= s[1];
      s_wp <= s[0];
      s_addr <= a;
      s_route <= r;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (12) @(posedge pclk);
   endtask
   task automatic cmd(input logic [7:0] op, input logic exp_nr);
      apb(1'b1, `DJC_OFS_CMD, {24'h0, op});
      // the answer latches two edges after the write lands
      repeat (2) @(posedge pclk);
      apb(1'b0, `DJC_OFS_CMD, 32'h0);
      chk_bit(rd[`DJC_CMD_DONE_BIT], 1'b1);
      chk_bit(rd[`DJC_CMD_NR_BIT], exp_nr);
   endtask
   task automatic tx_chk;
      for (int i = 0; i < 4; i++) begin
         djc_host_model_i.send(bytes[i]);
         repeat (2) @(posedge pclk);
         chk_bit(tx_parity, ~^bytes[i]);
      end
   endtask
   task automatic counts(input int st, input int pe, input int rp);
      settle();
      chk(32'(djc_host_model_i.n_start), 32'(st));
      chk(32'(djc_host_model_i.n_perr), 32'(pe));
      chk(32'(djc_host_model_i.n_reply), 32'(rp));
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ************
   // tests
   // ************
   initial begin
      restart(8'h3F, 4'hF, 2'h0);
      apb(1'b0, `DJC_OFS_STAT, 32'h0);
      chk({28'h0, rd[6:3]}, 32'h7);
      chk_bit(rd[0], 1'b1);
      chk_bit(spin_en, 1'b1);
      chk_bit(ua_en, 1'b0);
      chk_bit(par_chk_en, 1'b1);
      apb(1'b1, `DJC_OFS_CTRL, 32'h0);
      settle();
      chk_bit(scsi1_mode, 1'b1);
      chk_bit(wprot, 1'b1);
      counts(1, 0, 0);
      djc_host_model_i.pulse(0);
      djc_host_model_i.pulse(2);
      djc_host_model_i.pulse(1);
      counts(2, 1, 1);
      tx_chk();
      $display("test all_shorted done");
      restart(8'h00, 4'h5, 2'h3);
      chk({28'h0, bus_id}, 32'h5);
      chk_bit(spin_en, 1'b0);
      chk_bit(ua_en, 1'b1);
      chk_bit(par_chk_en, 1'b0);
      chk_bit(scsi1_mode, 1'b0);
      chk_bit(wprot, 1'b0);
      chk_bit(sync_oe, 1'b0);
      chk({30'h0, sync_route}, 32'h0);
      s_addr <= 4'h2;
      djc_host_model_i.pulse(0);
      djc_host_model_i.pulse(2);
      djc_host_model_i.pulse(1);
      counts(0, 0, 1);
      chk({28'h0, bus_id}, 32'h5);
      tx_chk();
      cmd(8'h28, 1'b1);
      for (int i = 0; i < 4; i++) begin
         cmd(free_ops[i], 1'b0);
      end
      cmd(`DJC_OP_START, 1'b0);
      settle();
      chk_bit(spin_en, 1'b1);
      chk_bit(unit_ready, 1'b0);
      at_speed <= 1'b1;
      repeat (2) @(posedge pclk);
      chk_bit(unit_ready, 1'b1);
      cmd(8'h28, 1'b0);
      apb(1'b1, `DJC_OFS_CTRL, 32'h1);
      settle();
      chk_bit(scsi1_mode, 1'b1);
      apb(1'b1, `DJC_OFS_CTRL, 32'h2);
      settle();
      chk_bit(wprot, 1'b1);
      chk_bit(scsi1_mode, 1'b0);
      $display("test all_open done");
      apb(1'b1, `DJC_OFS_CTRL, 32'h0C);
      settle();
      chk({29'h0, sync_oe, lock_ext, sync_route == 2'h3}, 32'h3);
      x0 = lock_ref;
      repeat (8) @(posedge pclk);
      chk_bit(lock_ref, ~x0);
      apb(1'b1, `DJC_OFS_CTRL, 32'h14);
      settle();
      chk({30'h0, sync_oe, lock_ext}, 32'h2);
      x0 = sync_out;
      repeat (4) @(posedge pclk);
      chk_bit(sync_out, ~x0);
      apb(1'b1, `DJC_OFS_CTRL, 32'h1C);
      settle();
      chk_bit(sync_oe, 1'b1);
      apb(1'b1, `DJC_OFS_CTRL, 32'h04);
      settle();
      chk({29'h0, sync_oe, lock_ext, lock_ref}, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      $display("test sync_and_bus done");
      wrap_up();
   end
   initial begin
      #300000;
      fail_count++;
      wrap_up();
   end
endmodule
